// *** design/pps_pkg.sv ***
// package for the port pin sense, interrupt and event block
package pps_pkg;

	localparam int NPIN            = 8;
	localparam int ASYNC_FULL_PIN  = 2;

	localparam logic [7:0] OFS_PIN_CFG0  = 8'h00;
	localparam logic [7:0] OFS_IRQ_CTRL  = 8'h20;
	localparam logic [7:0] OFS_IRQ0_SEL  = 8'h24;
	localparam logic [7:0] OFS_IRQ1_SEL  = 8'h28;
	localparam logic [7:0] OFS_IRQ_FLAGS = 8'h2c;
	localparam logic [7:0] OFS_PIN_IN    = 8'h30;
	localparam logic [7:0] OFS_OUT_CTRL  = 8'h34;

	localparam int CFG_SLEW_BIT   = 7;
	localparam int CFG_INV_BIT    = 6;
	localparam int CFG_SENSE_LSB  = 0;
	localparam int IRQ0_EN_LSB    = 0;
	localparam int IRQ1_EN_LSB    = 2;
	localparam int OUT_CLK_BIT    = 0;
	localparam int OUT_EVT_BIT    = 1;
	localparam int OUT_PSEL_LSB   = 4;

	localparam logic [7:0] RST_PIN_CFG  = 8'h00;
	localparam logic [3:0] RST_IRQ_CTRL = 4'h0;
	localparam logic [7:0] RST_IRQ_SEL  = 8'h00;
	localparam logic [6:0] RST_OUT_CTRL = 7'h00;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	typedef enum logic [1:0] {
		SENSE_BOTH,
		SENSE_RISE,
		SENSE_FALL,
		SENSE_LOW
	} pps_sense_t;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} pps_ahb_req_t;

	typedef struct packed {
		logic out_take;
		logic out_val;
		logic dir_take;
		logic dir_val;
	} pps_ovr_t;

endpackage

// *** design/pps_port_sense.sv ***
// port pin sensing, two port interrupts, pin events, override and clock/event output
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps

module pps_port_sense #(
	parameter int NPIN = pps_pkg::NPIN
) (
	input  wire logic                           ref_clk,
	input  wire logic                           rstn,
	input  wire pps_pkg::pps_ahb_req_t          ahb_req,
	output logic [31:0]                         hrdata,
	output logic                                hreadyout,
	output logic                                hresp,
	input  wire logic [NPIN-1:0]                pin_in,
	output logic [NPIN-1:0]                     pin_out,
	output logic [NPIN-1:0]                     pin_oe,
	output logic [NPIN-1:0]                     slew_limit_enable,
	input  wire logic [NPIN-1:0]                sw_out_val,
	input  wire logic [NPIN-1:0]                sw_dir,
	input  wire pps_pkg::pps_ovr_t [NPIN-1:0]   periph_ovr,
	input  wire logic                           evch0,
	output logic [1:0]                          port_irq_request,
	output logic [NPIN-1:0]                     pin_event,
	output logic                                wake_request
);
	import pps_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// sense match, shared by interrupt and event paths

	function automatic logic sense_hit(
		input logic [1:0] sense,
		input logic       prev,
		input logic       cur
	);
		logic r;
		r = 1'b0;
		unique case (pps_sense_t'(sense))
			SENSE_BOTH: r = prev ^ cur;
			SENSE_RISE: r = ~prev & cur;
			SENSE_FALL: r = prev & ~cur;
			SENSE_LOW:  r = ~cur;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic [7:0]       pin_cfg_reg [NPIN];
	logic [3:0]       irq_ctrl_r;
	logic [NPIN-1:0]  irq0_pin_select;
	logic [NPIN-1:0]  irq1_pin_select;
	logic [1:0]       port_irq_flag;
	logic [6:0]       out_ctrl_r;

	logic [NPIN-1:0]  invert_io_enable;
	logic [1:0]       sense_sel [NPIN];
	logic [1:0]       irq_en;

	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			invert_io_enable[i]  = pin_cfg_reg[i][CFG_INV_BIT];
			slew_limit_enable[i] = pin_cfg_reg[i][CFG_SLEW_BIT];
			sense_sel[i]         = pin_cfg_reg[i][CFG_SENSE_LSB +: 2];
		end
	end

	// a nonzero level field enables the interrupt
	assign irq_en[0] = |irq_ctrl_r[IRQ0_EN_LSB +: 2];
	assign irq_en[1] = |irq_ctrl_r[IRQ1_EN_LSB +: 2];

	////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave, zero wait, always okay

	logic        wr_pend_r;
	logic [7:0]  wr_addr_r;
	logic        addr_ok;
	logic        take;

	assign take = ahb_req.hsel && ahb_req.hready &&
		(ahb_req.htrans == HTRANS_NONSEQ || ahb_req.htrans == HTRANS_SEQ);
	assign addr_ok   = (ahb_req.haddr[31:8] == 24'h000000);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= take && ahb_req.hwrite && addr_ok;
			wr_addr_r <= ahb_req.haddr[7:0];
		end
	end

	logic [NPIN-1:0] pin_sync_r;

	function automatic logic [31:0] read_mux(input logic [7:0] a);
		logic [31:0] d;
		d = 32'h00000000;
		for (int i = 0; i < NPIN; i++) begin
			if (a == OFS_PIN_CFG0 + 8'(4 * i))
				d = {24'h000000, pin_cfg_reg[i][7:6], 4'h0, pin_cfg_reg[i][1:0]};
		end
		unique case (a)
			OFS_IRQ_CTRL:  d = {28'h0000000, irq_ctrl_r};
			OFS_IRQ0_SEL:  d = {24'h000000, irq0_pin_select};
			OFS_IRQ1_SEL:  d = {24'h000000, irq1_pin_select};
			OFS_IRQ_FLAGS: d = {30'h0, port_irq_flag};
			OFS_PIN_IN:    d = {24'h000000, pin_sync_r};
			OFS_OUT_CTRL:  d = {25'h0, out_ctrl_r};
			default:       d = d;
		endcase
		return d;
	endfunction

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			hrdata <= 32'h00000000;
		else if (take && !ahb_req.hwrite && addr_ok)
			hrdata <= read_mux(ahb_req.haddr[7:0]);
		else
			hrdata <= 32'h00000000;
	end

	logic [31:0] wd;
	assign wd = ahb_req.hwdata;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NPIN; i++)
				pin_cfg_reg[i] <= RST_PIN_CFG;
			irq_ctrl_r      <= RST_IRQ_CTRL;
			irq0_pin_select <= RST_IRQ_SEL;
			irq1_pin_select <= RST_IRQ_SEL;
			out_ctrl_r      <= RST_OUT_CTRL;
		end else if (wr_pend_r) begin
			for (int i = 0; i < NPIN; i++)
				if (wr_addr_r == OFS_PIN_CFG0 + 8'(4 * i))
					pin_cfg_reg[i] <= {wd[7:6], 4'h0, wd[1:0]};
			if (wr_addr_r == OFS_IRQ_CTRL)
				irq_ctrl_r <= wd[3:0];
			if (wr_addr_r == OFS_IRQ0_SEL)
				irq0_pin_select <= wd[NPIN-1:0];
			if (wr_addr_r == OFS_IRQ1_SEL)
				irq1_pin_select <= wd[NPIN-1:0];
			if (wr_addr_r == OFS_OUT_CTRL)
				out_ctrl_r <= wd[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// synchronous sensing

	logic [NPIN-1:0] pin_meta_r;
	logic [NPIN-1:0] pin_prev_r;
	logic [NPIN-1:0] s_cur;
	logic [NPIN-1:0] s_prev;
	logic [NPIN-1:0] sync_hit;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
			pin_prev_r <= '0;
		end else begin
			pin_meta_r <= pin_in;
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	// inversion applies before sensing, so low sense on an inverted pin sees high
	assign s_cur  = pin_sync_r ^ invert_io_enable;
	assign s_prev = pin_prev_r ^ invert_io_enable;

	always_comb begin
		for (int i = 0; i < NPIN; i++)
			sync_hit[i] = sense_hit(sense_sel[i], s_prev[i], s_cur[i]);
	end

	////////////////////////////////////////////////////////////////////////////
	// pin 2 clockless edge latch: toggles run on the pin itself

	logic rise_tgl_r;
	logic fall_tgl_r;
	logic [1:0] rise_sy_r;
	logic [1:0] fall_sy_r;
	logic rise_seen_r;
	logic fall_seen_r;
	logic rise_chg;
	logic fall_chg;
	logic async_hit;

	always_ff @(posedge pin_in[ASYNC_FULL_PIN] or negedge rstn) begin
		if (!rstn)
			rise_tgl_r <= 1'b0;
		else
			rise_tgl_r <= ~rise_tgl_r;
	end

	always_ff @(negedge pin_in[ASYNC_FULL_PIN] or negedge rstn) begin
		if (!rstn)
			fall_tgl_r <= 1'b0;
		else
			fall_tgl_r <= ~fall_tgl_r;
	end

	// the toggle stays different from its seen copy until the clock runs again
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rise_sy_r   <= 2'h0;
			fall_sy_r   <= 2'h0;
			rise_seen_r <= 1'b0;
			fall_seen_r <= 1'b0;
		end else begin
			rise_sy_r   <= {rise_sy_r[0], rise_tgl_r};
			fall_sy_r   <= {fall_sy_r[0], fall_tgl_r};
			rise_seen_r <= rise_sy_r[1];
			fall_seen_r <= fall_sy_r[1];
		end
	end

	assign rise_chg = rise_sy_r[1] ^ rise_seen_r;
	assign fall_chg = fall_sy_r[1] ^ fall_seen_r;

	always_comb begin
		logic up;
		logic dn;
		up = invert_io_enable[ASYNC_FULL_PIN] ? fall_chg : rise_chg;
		dn = invert_io_enable[ASYNC_FULL_PIN] ? rise_chg : fall_chg;
		unique case (pps_sense_t'(sense_sel[ASYNC_FULL_PIN]))
			SENSE_BOTH: async_hit = up | dn;
			SENSE_RISE: async_hit = up;
			SENSE_FALL: async_hit = dn;
			SENSE_LOW:  async_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt flags and requests

	logic [NPIN-1:0] irq_hit;
	logic [1:0]      flag_set;
	logic [1:0]      flag_clr;

	always_comb begin
		irq_hit = sync_hit;
		irq_hit[ASYNC_FULL_PIN] = sync_hit[ASYNC_FULL_PIN] | async_hit;
	end

	assign flag_set[0] = |(irq_hit & irq0_pin_select);
	assign flag_set[1] = |(irq_hit & irq1_pin_select);
	assign flag_clr    = (wr_pend_r && wr_addr_r == OFS_IRQ_FLAGS) ? wd[1:0] : 2'h0;

	// set beats a same-cycle write-one clear
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			port_irq_flag <= 2'h0;
		else
			port_irq_flag <= (port_irq_flag & ~flag_clr) | flag_set;
	end

	// a held low keeps setting the flag, so the request stays up after clears
	assign port_irq_request = port_irq_flag & irq_en;

	////////////////////////////////////////////////////////////////////////////
	// clockless wake: level and change seen directly on the pads

	logic [NPIN-1:0] wake_pin;
	logic [NPIN-1:0] raw_v;

	assign raw_v = pin_in ^ invert_io_enable;

	// limited pins with both-edge sense only flag a change against the last clocked sample; if it
	// returns before the clock is back, the flag never sets
	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			unique case (pps_sense_t'(sense_sel[i]))
				SENSE_LOW:  wake_pin[i] = ~raw_v[i];
				SENSE_BOTH: wake_pin[i] = raw_v[i] ^ s_cur[i];
				default:    wake_pin[i] = 1'b0;
			endcase
		end
		if (sense_sel[ASYNC_FULL_PIN] != 2'(SENSE_LOW))
			wake_pin[ASYNC_FULL_PIN] = (rise_tgl_r ^ rise_sy_r[1]) |
				(fall_tgl_r ^ fall_sy_r[1]) | async_hit;
	end

	assign wake_request = (irq_en[0] && |(wake_pin & irq0_pin_select)) ||
		(irq_en[1] && |(wake_pin & irq1_pin_select));

	////////////////////////////////////////////////////////////////////////////
	// pin events, clocked only

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			pin_event <= '0;
		else
			for (int i = 0; i < NPIN; i++)
				pin_event[i] <= (sense_sel[i] == 2'(SENSE_LOW)) ?
					s_cur[i] : sync_hit[i];
	end

	////////////////////////////////////////////////////////////////////////////
	// output path: override, inversion, clock and event routing

	logic [NPIN-1:0] out_r;
	logic [NPIN-1:0] oe_r;
	logic [2:0]      route_pin;
	logic            clk_route;
	logic            evt_route;

	assign route_pin = out_ctrl_r[OUT_PSEL_LSB +: 3];
	assign clk_route = out_ctrl_r[OUT_CLK_BIT];
	assign evt_route = out_ctrl_r[OUT_EVT_BIT];

	// the event is registered once, so it keeps its full width, one cycle late
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			out_r <= '0;
			oe_r  <= '0;
		end else begin
			for (int i = 0; i < NPIN; i++) begin
				logic v;
				logic d;
				v = periph_ovr[i].out_take ? periph_ovr[i].out_val : sw_out_val[i];
				d = periph_ovr[i].dir_take ? periph_ovr[i].dir_val : sw_dir[i];
				if (evt_route && route_pin == 3'(i)) begin
					out_r[i] <= evch0;
					oe_r[i]  <= 1'b1;
				end else begin
					out_r[i] <= v ^ invert_io_enable[i];
					oe_r[i]  <= d | (clk_route && route_pin == 3'(i));
				end
			end
		end
	end

	// the clock passes straight through; a register could only halve it
	always_comb begin
		pin_out = out_r;
		if (clk_route && !evt_route)
			pin_out[route_pin] = ref_clk;
	end

	assign pin_oe = oe_r;

endmodule // pps_port_sense

// *** test/pps_port_sense_chk.sv ***
// assertion checker for the port pin sense block
`timescale 1ns/100ps
module pps_port_sense_chk #(
	parameter int NPIN = 8
) (
	input wire logic                  ref_clk,
	input wire logic                  rstn,
	input wire pps_pkg::pps_ahb_req_t ahb_req,
	input wire logic [31:0]           hrdata,
	input wire logic                  hreadyout,
	input wire logic                  hresp,
	input wire logic [NPIN-1:0]       pin_in,
	input wire logic [NPIN-1:0]       slew_limit_enable,
	input wire logic [1:0]            port_irq_request,
	input wire logic [NPIN-1:0]       pin_event
);
	import pps_pkg::*;
	logic            acc, rd_a, wr_a;
	logic [NPIN-1:0] pin_q_r;
	logic [2:0]      quiet_r;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////
	assign acc  = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1] & (ahb_req.haddr[31:8] == 24'h0);
	assign rd_a = acc & ~ahb_req.hwrite;
	assign wr_a = acc & ahb_req.hwrite;
	// cycles since the last pad change or register write, saturating
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pin_q_r <= '0;
			quiet_r <= 3'h0;
		end else begin
			pin_q_r <= pin_in;
			if (pin_in != pin_q_r || wr_a)
				quiet_r <= 3'h0;
			else if (quiet_r != 3'h7)
				quiet_r <= quiet_r + 3'h1;
		end
	end
	////////////////////////////////////////////////////////////////
	property p_ready; hreadyout == 1'b1; endproperty
	a_ready: assert property (p_ready) else $error("bus wait state seen");
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("bus error response seen");
	property p_rdata; hrdata != 32'h0 |-> $past(rd_a); endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside read data phase");
	property p_slew; !$stable(slew_limit_enable) |-> $past(wr_a, 2); endproperty
	a_slew: assert property (p_slew) else $error("slew control moved without write");
	property p_req_hold; |($past(port_irq_request) & ~port_irq_request) |-> $past(wr_a, 2); endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped without write");
	property p_req_late; |(port_irq_request & ~$past(port_irq_request)) |-> quiet_r != 3'h0; endproperty
	a_req_late: assert property (p_req_late) else $error("request before pad was sampled");
	property p_evt_quiet; quiet_r == 3'h7 |-> $stable(pin_event); endproperty
	a_evt_quiet: assert property (p_evt_quiet) else $error("event moved on quiet pads");
	property p_evt_late; |(pin_event & ~$past(pin_event)) |-> quiet_r != 3'h0; endproperty
	a_evt_late: assert property (p_evt_late) else $error("event before pad was sampled");
	c_irq0: cover property ($rose(port_irq_request[0]));
	c_irq1: cover property ($rose(port_irq_request[1]));
	c_evt: cover property (pin_event != '0);
endmodule // pps_port_sense_chk

bind pps_port_sense pps_port_sense_chk #(.NPIN(NPIN)) chk_i (.ref_clk(ref_clk), .rstn(rstn),
	.ahb_req(ahb_req), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
	.slew_limit_enable(slew_limit_enable), .port_irq_request(port_irq_request),
	.pin_event(pin_event));

// *** test/pps_pad_model.sv ***
// pad model: drives the port input pins as the bench commands
`timescale 1ns/100ps
module pps_pad_model (
	input  wire logic [7:0] want,
	output logic      [7:0] pin_in
);
	// pads settle after the command, never on a clock edge; values hold until changed
	initial pin_in = 8'h00;
	always @(want) pin_in <= #1 want;
endmodule // pps_pad_model

// *** test/testbench.sv ***
// self-checking testbench for the port pin sense block
`timescale 1ns/100ps
module testbench;
	import pps_pkg::*;
	logic            ref_clk = 0, rstn, run = 1, evch0 = 0;
	pps_ahb_req_t    req = '0;
	logic [31:0]     hrdata, rd;
	logic            hreadyout, hresp, wake_request;
	logic [7:0]      pin_want = 0, sw_out_val = 0, sw_dir = 0;
	logic [7:0]      pin_in, pin_out, pin_oe, slew_limit_enable, pin_event;
	pps_ovr_t [7:0]  periph_ovr = '0;
	logic [1:0]      port_irq_request;
	int              miscompares = 0, checked = 0, ev_n = 0, po_n = 0;
	always #2 if (run) ref_clk = ~ref_clk;
	always @* req.hready <= hreadyout;
	always @(posedge ref_clk) begin
		ev_n <= ev_n + pin_event[0];
		po_n <= po_n + pin_out[4];
	end
	pps_pad_model pps_pad_model_i (.want(pin_want), .pin_in(pin_in));
	pps_port_sense pps_port_sense_i (.ref_clk(ref_clk), .rstn(rstn), .ahb_req(req), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.slew_limit_enable(slew_limit_enable), .sw_out_val(sw_out_val), .sw_dir(sw_dir),
		.periph_ovr(periph_ovr), .evch0(evch0), .port_irq_request(port_irq_request),
		.pin_event(pin_event), .wake_request(wake_request));
	////////////////////////////////////////////////////////////////
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one single word transfer; read data is taken at the closing edge
	task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
		@(posedge ref_clk);
		req.hsel <= 1'b1;
		req.haddr <= a;
		req.htrans <= HTRANS_NONSEQ;
		req.hwrite <= w;
		req.hsize <= 3'h2;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		req.htrans <= 2'h0;
		req.hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic print_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [7:0] ofs [6] = '{OFS_PIN_CFG0, OFS_IRQ_CTRL, OFS_IRQ0_SEL, OFS_IRQ1_SEL,
			OFS_IRQ_FLAGS, OFS_OUT_CTRL};
		foreach (ofs[i]) begin
			bus(0, ofs[i], 0);
			chk("reset_value", rd, 0);
		end
		bus(1, 32'h1c, 32'hffffffff);
		bus(0, 32'h1c, 0);
		chk("pin_cfg7", rd, 32'hc3);
		chk("slew7", slew_limit_enable, 8'h80);
		bus(1, 32'h1c, 0);
		bus(1, 32'h100 + OFS_IRQ0_SEL, 32'hff);
		bus(0, OFS_IRQ0_SEL, 0);
		chk("far_write", rd, 0);
		bus(0, 32'h3c, 0);
		chk("unmapped", rd, 0);
	endtask
	task automatic t_sense;
		logic [1:0] e;
		int n0;
		bus(1, OFS_IRQ0_SEL, 32'h1);
		bus(1, OFS_IRQ_CTRL, 32'h1);
		for (int k = 0; k < 3; k++) begin
			e = (k == 0) ? 2'h3 : (k == 1) ? 2'h2 : 2'h1;
			bus(1, OFS_PIN_CFG0, k);
			for (int v = 1; v >= 0; v--) begin
				bus(1, OFS_IRQ_FLAGS, 32'h3);
				n0 = ev_n;
				@(posedge ref_clk);
				pin_want <= 8'(v);
				repeat (3) @(posedge ref_clk);
				chk("irq0_early", port_irq_request[0], 0);
				@(posedge ref_clk);
				chk("irq0_edge", port_irq_request[0], e[v]);
				repeat (6) @(posedge ref_clk);
				chk("pin0_events", ev_n - n0, e[v]);
			end
		end
	endtask
	task automatic lvl(logic [7:0] v, logic [1:0] r, logic ev);
		@(posedge ref_clk);
		pin_want <= v;
		repeat (8) @(posedge ref_clk);
		bus(1, OFS_IRQ_FLAGS, 32'h3);
		repeat (2) @(posedge ref_clk);
		chk("irq_level", port_irq_request, r);
		chk("pin3_event", pin_event[3], ev);
	endtask
	task automatic t_level;
		bus(1, OFS_IRQ1_SEL, 32'h8);
		bus(1, OFS_IRQ_CTRL, 32'h5);
		bus(1, OFS_PIN_CFG0 + 12, 32'h3);
		lvl(8'h00, 2'h2, 1'b0);
		lvl(8'h08, 2'h0, 1'b1);
		bus(0, OFS_PIN_IN, 0);
		chk("pin_in_reg", rd, 32'h8);
		bus(1, OFS_PIN_CFG0 + 12, 32'h43);
		lvl(8'h08, 2'h2, 1'b0);
		lvl(8'h00, 2'h0, 1'b1);
	endtask
	task automatic t_mask;
		bus(1, OFS_IRQ_CTRL, 32'h0);
		bus(1, OFS_IRQ0_SEL, 32'h2);
		bus(1, OFS_IRQ1_SEL, 32'h0);
		bus(1, OFS_PIN_CFG0 + 4, 32'h0);
		bus(1, OFS_IRQ_FLAGS, 32'h3);
		@(posedge ref_clk);
		pin_want <= 8'h02;
		repeat (8) @(posedge ref_clk);
		chk("irq_off", port_irq_request, 2'h0);
		bus(0, OFS_IRQ_FLAGS, 0);
		chk("flags", rd, 32'h1);
		bus(1, OFS_IRQ_CTRL, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("irq_on", port_irq_request, 2'h1);
		bus(1, OFS_IRQ_FLAGS, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("irq_clear", port_irq_request, 2'h0);
	endtask
	// pin 2 rises and pin 5 pulses while the clock stands still
	task automatic t_async;
		bus(1, OFS_PIN_CFG0 + 8, 32'h1);
		bus(1, OFS_PIN_CFG0 + 20, 32'h0);
		bus(1, OFS_IRQ0_SEL, 32'h4);
		bus(1, OFS_IRQ1_SEL, 32'h20);
		bus(1, OFS_IRQ_CTRL, 32'h5);
		bus(1, OFS_IRQ_FLAGS, 32'h3);
		@(negedge ref_clk);
		run = 0;
		#10 pin_want <= 8'h24;
		#5 chk("wake_edge", wake_request, 1);
		#5 pin_want <= 8'h00;
		#5 chk("wake_latched", wake_request, 1);
		#5 run = 1;
		repeat (8) @(posedge ref_clk);
		chk("irq_async", port_irq_request, 2'h1);
		chk("wake_done", wake_request, 0);
		// limited pin with rising sense must not wake without a clock
		bus(1, OFS_PIN_CFG0 + 20, 32'h1);
		@(negedge ref_clk);
		run = 0;
		#10 pin_want <= 8'h20;
		#5 chk("wake_rise_limited", wake_request, 0);
		pin_want <= 8'h00;
		#10 run = 1;
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic t_out;
		int n0;
		bus(1, OFS_OUT_CTRL, 32'h42);
		n0 = po_n;
		@(posedge ref_clk);
		evch0 <= 1'b1;
		@(posedge ref_clk);
		evch0 <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("evt_on_pin", po_n - n0, 1);
		bus(1, OFS_OUT_CTRL, 32'h41);
		repeat (2) @(posedge ref_clk);
		#1 chk("clk_hi", pin_out[4], 1);
		@(negedge ref_clk);
		#1 chk("clk_lo", pin_out[4], 0);
		@(posedge ref_clk);
		periph_ovr[6] <= 4'hf;
		repeat (3) @(posedge ref_clk);
		chk("override", {pin_oe[6], pin_out[6]}, 2'h3);
		bus(1, OFS_PIN_CFG0 + 24, 32'hc0);
		repeat (3) @(posedge ref_clk);
		chk("inv_out", pin_out[6], 0);
		chk("slew6", slew_limit_enable, 8'h40);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		// reset starts unknown so its fall is an edge for the pad-clocked flops
		rstn <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
		t_regs;
		t_sense;
		t_level;
		t_mask;
		t_async;
		t_out;
		print_verdict;
	end
	// the whole sequence needs well under ten thousand cycles
	initial begin
		#40000;
		miscompares++;
		print_verdict;
	end
endmodule // testbench
